//--- adc_core_trim_registers.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps

module adc_core_trim_registers (
   input wire logic I_CLK, // System clock, 200 MHz.
   input wire logic I_RST_N, // Synchronous reset, active low.
   input wire logic [trim_pkg::ADDR_W-1:0] I_ADDR, // Register byte address.
   input wire logic [trim_pkg::DATA_W-1:0] I_WDATA, // Register write data.
   input wire logic I_WR, // Write strobe, one cycle.
   input wire logic I_RD, // Read strobe, one cycle.
   output logic [trim_pkg::DATA_W-1:0] O_RDATA, // Read data, cycle after I_RD.
   input wire logic I_CORE2_SEL_B, // Core 2 samples pair B when high.
   input wire logic I_CORE3_SEL_D, // Core 3 samples pair D when high.
   output logic [trim_pkg::OFS_W-1:0] O_CORE2_OFS, // Core 2 offset trim.
   output logic [trim_pkg::OFS_W-1:0] O_CORE3_OFS, // Core 3 offset trim.
   output logic [trim_pkg::OFS_W-1:0] O_CORE4_OFS, // Core 4 offset trim.
   output logic [trim_pkg::OFS_W-1:0] O_CORE5_OFS, // Core 5 offset trim.
   output logic [trim_pkg::GAIN_W-1:0] O_CORE0_GAIN, // Core 0 fine gain trim.
   output logic [trim_pkg::GAIN_W-1:0] O_CORE1_GAIN, // Core 1 fine gain trim.
   output logic O_FUSE_RD, // Fuse read strobe, one cycle.
   output logic [trim_pkg::IDX_W-1:0] O_FUSE_ADDR, // Fuse word address.
   input wire logic [trim_pkg::DATA_W-1:0] I_FUSE_DATA, // Fuse word, cycle after strobe.
   output logic O_FUSE_BUSY // High while fuse values are loading.
);
   import trim_pkg::*;

   // ****************************************************************
   // Address decode.
   // ****************************************************************

   // Bit 3 of the decode says the address hits a trim register, bits 2:0 pick it.
   // Unlisted addresses, odd or even, fall through, so a stray access reads zero.
   // Maps a byte address to a hit flag and a register index.
   function automatic logic [3:0] decode_addr(input logic [ADDR_W-1:0] addr);
      logic [3:0] res;
      res = 4'h0;
      case (addr)
         CORE2_INPUT_A_OFFSET_TRIM_ADDR: res = {1'b1, IDX_C2A};
         CORE2_INPUT_B_OFFSET_TRIM_ADDR: res = {1'b1, IDX_C2B};
         CORE3_INPUT_C_OFFSET_TRIM_ADDR: res = {1'b1, IDX_C3C};
         CORE3_INPUT_D_OFFSET_TRIM_ADDR: res = {1'b1, IDX_C3D};
         CORE4_OFFSET_TRIM_ADDR: res = {1'b1, IDX_C4};
         CORE5_OFFSET_TRIM_ADDR: res = {1'b1, IDX_C5};
         CORE0_FINE_GAIN_TRIM_ADDR: res = {1'b1, IDX_G0};
         CORE1_FINE_GAIN_TRIM_ADDR: res = {1'b1, IDX_G1};
         default: res = 4'h0;
      endcase
      return res;
   endfunction : decode_addr

   // Returns the implemented bits of a register index.
   // Offset words keep all 16 bits, gain words only their low byte.
   function automatic logic [DATA_W-1:0] reg_mask(input int idx);
      return (idx < NUM_OFS) ? OFS_MASK : GAIN_MASK;
   endfunction : reg_mask

   logic [DATA_W-1:0] regs_q [NUM_REGS]; // Trim register storage.
   logic [3:0] wr_dec; // Decoded write address.
   logic [3:0] rd_dec; // Decoded read address.
   logic wr_hit; // Write to a mapped register.
   logic load_en; // Fuse word arrives this cycle.

   assign wr_dec = decode_addr(I_ADDR);
   assign rd_dec = decode_addr(I_ADDR);
   assign wr_hit = I_WR && wr_dec[3] && !O_FUSE_BUSY;

   // ****************************************************************
   // Power-up fuse load.
   // ****************************************************************
   load_state_t state_q; // Load sequencer state.
   logic [IDX_W-1:0] fuse_idx_q; // Word being loaded.

   // The fuse store answers one cycle after its strobe, so each word takes
   // three cycles: strobe out, data on the wire, data captured.
   // Software writes are refused until the last word has landed.
   assign load_en = (state_q == LOAD_DATA);

   // Walks the fuse words once after reset, one word every three cycles.
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         // Every reset starts the load again from word zero.
         state_q <= LOAD_ADDR;
         fuse_idx_q <= 3'h0;
      end else begin
         // Advance the load by one step.
         case (state_q)
            LOAD_ADDR: begin
               // The strobe for the current word leaves this cycle.
               state_q <= LOAD_WAIT;
            end
            LOAD_WAIT: begin
               // The fuse store is putting the word on its data lines.
               state_q <= LOAD_DATA;
            end
            LOAD_DATA: begin
               // Stop after the last word, else step to the next one.
               if (fuse_idx_q == IDX_LAST) begin
                  state_q <= LOAD_IDLE;
               end else begin
                  fuse_idx_q <= fuse_idx_q + 3'h1;
                  state_q <= LOAD_ADDR;
               end
            end
            LOAD_IDLE: begin
               // The load is over until the next reset.
               state_q <= LOAD_IDLE;
            end
            default: begin
               // An unknown state ends the load rather than looping.
               state_q <= LOAD_IDLE;
            end
         endcase
      end
   end

   // Drives the fuse strobe, address and busy flag from flip-flops.
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         // Busy stands from reset so no write slips in before the load.
         O_FUSE_RD <= 1'b0;
         O_FUSE_ADDR <= 3'h0;
         O_FUSE_BUSY <= 1'b1;
      end else begin
         // Busy drops in the cycle after the last word is captured.
         O_FUSE_RD <= (state_q == LOAD_ADDR);
         O_FUSE_ADDR <= fuse_idx_q;
         O_FUSE_BUSY <= !(load_en && fuse_idx_q == IDX_LAST) &&
                        (state_q != LOAD_IDLE);
      end
   end

   // ****************************************************************
   // Trim register storage.
   // ****************************************************************
   // One storage process per register keeps its load and its write together.
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      // Fuse load first, then software writes; only real bits are kept.
      always_ff @(posedge I_CLK) begin
         if (!I_RST_N) begin
            // Nominal value until the fuse word arrives.
            regs_q[g] <= (g < NUM_OFS) ? OFS_RST : GAIN_RST;
         end else if (load_en && fuse_idx_q == IDX_W'(g)) begin
            // The factory word replaces the nominal value.
            regs_q[g] <= I_FUSE_DATA & reg_mask(g);
         end else if (wr_hit && wr_dec[2:0] == IDX_W'(g)) begin
            // A mapped write outside the load takes effect next cycle.
            regs_q[g] <= I_WDATA & reg_mask(g);
         end
      end
   end

   // ****************************************************************
   // Register read port.
   // ****************************************************************

   // Read data stand for one cycle only, then fall back to zero.
   // Returns the addressed register in the cycle after the strobe.
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         // Nothing to return while in reset.
         O_RDATA <= 16'h0000;
      end else if (I_RD && rd_dec[3]) begin
         // A mapped read returns the stored word in full.
         O_RDATA <= regs_q[rd_dec[2:0]];
      end else begin
         O_RDATA <= 16'h0000; // Unmapped or idle reads give zero.
      end
   end

   // ****************************************************************
   // Trim outputs to the converter cores.
   // ****************************************************************

   // Outputs lag the registers and selects by one cycle, so a core never
   // sees a value that is half switched.
   // Picks the per-pair trim for the shared cores and forwards the rest.
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         // Cores see zero trims while the block is in reset.
         O_CORE2_OFS <= 12'h000;
         O_CORE3_OFS <= 12'h000;
         O_CORE4_OFS <= 12'h000;
         O_CORE5_OFS <= 12'h000;
         O_CORE0_GAIN <= 5'h00;
         O_CORE1_GAIN <= 5'h00;
      end else begin
         // Offset fields pass as plain unsigned codes.
         O_CORE2_OFS <= I_CORE2_SEL_B ? regs_q[IDX_C2B][OFS_W-1:0] :
                        regs_q[IDX_C2A][OFS_W-1:0];
         O_CORE3_OFS <= I_CORE3_SEL_D ? regs_q[IDX_C3D][OFS_W-1:0] :
                        regs_q[IDX_C3C][OFS_W-1:0];
         O_CORE4_OFS <= regs_q[IDX_C4][OFS_W-1:0];
         O_CORE5_OFS <= regs_q[IDX_C5][OFS_W-1:0];
         O_CORE0_GAIN <= regs_q[IDX_G0][GAIN_W-1:0];
         O_CORE1_GAIN <= regs_q[IDX_G1][GAIN_W-1:0];
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************

   // These checks watch the fuse walk, the register port and the trim outputs.
   // A write lands in its register the next cycle and on the core one cycle
   // later, which is why the write checks look two cycles ahead.

   // One fuse word: strobe, then data captured one cycle later.
   sequence fuse_step_s;
      O_FUSE_RD ##1 load_en;
   endsequence

   // Two quiet cycles, then the strobe for the following word.
   sequence fuse_gap_s;
      !O_FUSE_RD [*2] ##1 O_FUSE_RD;
   endsequence

   // Every strobe is followed by the capture of its word.
   chk_fuse_strobe_data: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      $rose(O_FUSE_RD) |-> fuse_step_s)
      else $error("Fuse word not captured after strobe.");

   // Words are fetched in order, one strobe every three cycles.
   chk_fuse_order: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      $rose(O_FUSE_RD) && O_FUSE_ADDR != IDX_LAST |->
      ##1 fuse_gap_s ##0 (O_FUSE_ADDR == $past(O_FUSE_ADDR, 3) + 3'h1))
      else $error("Fuse words not fetched in order.");

   // The core 4 offset takes the fuse word unchanged.
   chk_fuse_load_value: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      load_en && fuse_idx_q == IDX_C4 |=> regs_q[IDX_C4] == $past(I_FUSE_DATA))
      else $error("Core 4 offset did not take fuse value.");

   // The core 1 gain keeps only the low byte of its fuse word.
   chk_gain_fuse_load: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      load_en && fuse_idx_q == IDX_G1 |=>
      regs_q[IDX_G1] == ($past(I_FUSE_DATA) & GAIN_MASK))
      else $error("Core 1 gain did not take fuse value.");

   // The whole walk of eight words ends within a bounded time.
   chk_load_finishes: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      $rose(I_RST_N) |-> ##[20:26] !O_FUSE_BUSY)
      else $error("Fuse load did not finish in time.");

   // Once the walk is over the strobe and busy flag stay low.
   chk_load_idle_quiet: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      state_q == LOAD_IDLE |-> !O_FUSE_BUSY && !O_FUSE_RD)
      else $error("Fuse port active after the load.");

   // A write while the fuses load leaves the addressed register alone.
   chk_busy_write_drop: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      O_FUSE_BUSY && I_WR && wr_dec[3] && !(load_en && fuse_idx_q == wr_dec[2:0]) |=>
      regs_q[$past(wr_dec[2:0])] == $past(regs_q[wr_dec[2:0]]))
      else $error("Write accepted during the fuse load.");

   // Outside the cycle after a mapped read the read data rest at zero.
   chk_rdata_idle: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      !(I_RD && rd_dec[3]) |=> O_RDATA == 16'h0000)
      else $error("Read data did not return to zero.");

   // Gain words never hold anything above their low byte.
   chk_gain_upper_zero: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      regs_q[IDX_G0][15:8] == 8'h00 && regs_q[IDX_G1][15:8] == 8'h00)
      else $error("Gain register upper byte not zero.");

   // A read right after a write returns the new value.
   chk_write_readback: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit ##1 (I_RD && !I_WR && I_ADDR == $past(I_ADDR)) |=>
      O_RDATA == ($past(I_WDATA, 2) & reg_mask(int'($past(wr_dec[2:0], 2)))))
      else $error("Read did not return the last write.");

   // Core 2 follows its pair select one cycle later.
   chk_core2_select: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      1'b1 |=> O_CORE2_OFS == ($past(I_CORE2_SEL_B) ?
      $past(regs_q[IDX_C2B][OFS_W-1:0]) : $past(regs_q[IDX_C2A][OFS_W-1:0])))
      else $error("Core 2 offset from wrong input pair.");

   // A pair A write reaches core 2 while it samples pair A.
   chk_core2a_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit && I_ADDR == CORE2_INPUT_A_OFFSET_TRIM_ADDR ##1 !I_CORE2_SEL_B |=>
      O_CORE2_OFS == $past(I_WDATA[OFS_W-1:0], 2))
      else $error("Core 2 pair A write not applied.");

   // Core 3 follows its pair select one cycle later.
   chk_core3_select: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      1'b1 |=> O_CORE3_OFS == ($past(I_CORE3_SEL_D) ?
      $past(regs_q[IDX_C3D][OFS_W-1:0]) : $past(regs_q[IDX_C3C][OFS_W-1:0])))
      else $error("Core 3 offset from wrong input pair.");

   // A pair C write reaches core 3 while it samples pair C.
   chk_core3c_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit && I_ADDR == CORE3_INPUT_C_OFFSET_TRIM_ADDR ##1 !I_CORE3_SEL_D |=>
      O_CORE3_OFS == $past(I_WDATA[OFS_W-1:0], 2))
      else $error("Core 3 pair C write not applied.");

   // A core 5 write reaches the core two cycles later.
   chk_core5_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit && I_ADDR == CORE5_OFFSET_TRIM_ADDR |=>
      ##1 O_CORE5_OFS == $past(I_WDATA[OFS_W-1:0], 2))
      else $error("Core 5 offset write not applied.");

   // A core 0 gain write reaches the core two cycles later.
   chk_core0_fine_gain_trim_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit && I_ADDR == CORE0_FINE_GAIN_TRIM_ADDR |=>
      ##1 O_CORE0_GAIN == $past(I_WDATA[GAIN_W-1:0], 2))
      else $error("Core 0 gain write not applied.");

   // A core 1 gain write reaches the core two cycles later.
   chk_core1_fine_gain_trim_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit && I_ADDR == CORE1_FINE_GAIN_TRIM_ADDR |=>
      ##1 O_CORE1_GAIN == $past(I_WDATA[GAIN_W-1:0], 2))
      else $error("Core 1 gain write not applied.");

   // A core 4 write reaches the core two cycles later.
   chk_core4_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_N)
      wr_hit && I_ADDR == CORE4_OFFSET_TRIM_ADDR |=>
      ##1 O_CORE4_OFS == $past(I_WDATA[OFS_W-1:0], 2))
      else $error("Core 4 offset write not applied.");

endmodule : adc_core_trim_registers

//--- adc_core_trim_registers_tb.sv
`timescale 1ns/100ps

module adc_core_trim_registers_tb;
   import trim_pkg::*;

   // ****************************************************************
   // Stimulus table, fuse image and bench state.
   // ****************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr; // Register address.
      logic [DATA_W-1:0] wdata; // Value written by software.
      logic [DATA_W-1:0] rexp; // Value expected on read-back.
   } row_t;

   logic clk; // Bench clock, 5 ns period.
   logic rst_n; // Synchronous reset, active low.
   logic [ADDR_W-1:0] addr; // Bus address.
   logic [DATA_W-1:0] wdata; // Bus write data.
   logic wr; // Write strobe.
   logic rd_s; // Read strobe.
   logic sel_b; // Core 2 pair select.
   logic sel_d; // Core 3 pair select.
   logic [DATA_W-1:0] fuse_data = '0; // Fuse word returned to the block.
   logic [DATA_W-1:0] rdata; // Read data from the block.
   logic [OFS_W-1:0] c2, c3, c4, c5; // Core offset outputs.
   logic [GAIN_W-1:0] g0, g1; // Core gain outputs.
   logic fuse_rd; // Fuse read strobe.
   logic [IDX_W-1:0] fuse_addr; // Fuse word index.
   logic busy; // Fuse load in progress.
   logic [DATA_W-1:0] v; // Last value read.
   row_t rows [0:7]; // Ordinary write and read-back cases.
   logic [DATA_W-1:0] fz [0:7]; // Fuse contents, one word per register.
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   adc_core_trim_registers i_dut (
      .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd_s), .O_RDATA(rdata), .I_CORE2_SEL_B(sel_b), .I_CORE3_SEL_D(sel_d),
      .O_CORE2_OFS(c2), .O_CORE3_OFS(c3), .O_CORE4_OFS(c4), .O_CORE5_OFS(c5),
      .O_CORE0_GAIN(g0), .O_CORE1_GAIN(g1), .O_FUSE_RD(fuse_rd),
      .O_FUSE_ADDR(fuse_addr), .I_FUSE_DATA(fuse_data), .O_FUSE_BUSY(busy)
   );

   // ****************************************************************
   // Clock, fuse storage and hang guard.
   // ****************************************************************
   // The clock toggles every half period.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The fuse answers one cycle after the strobe; otherwise the word flips so stale data shows.
   always @(posedge clk) begin
      fuse_data <= fuse_rd ? fz[fuse_addr] : ~fuse_data;
   end

   // A hang is cut short well after the expected run of under two hundred cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end

   // ****************************************************************
   // Bus tasks and comparisons.
   // ****************************************************************
   // One write cycle; the strobe is left for the next task to drop.
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      rd_s <= 1'b0;
      addr <= a;
      wdata <= d;
   endtask : wr_reg

   // One read cycle; data are taken in the cycle after the strobe.
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      rd_s <= 1'b1;
      wr <= 1'b0;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   // Drops both strobes for one cycle.
   task automatic idle();
      @(posedge clk);
      wr <= 1'b0;
      rd_s <= 1'b0;
   endtask : idle

   // Compares a register read-back.
   task automatic chk_rd(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_rd

   // Compares a trim output towards a converter core.
   task automatic chk_out(input string n, input logic [11:0] e, input logic [11:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_out

   // Waits a bounded time for the fuse load to finish.
   task automatic wait_load();
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_out("busy", 12'h000, {11'h000, busy});
   endtask : wait_load

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      rst_n = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd_s = 1'b0;
      sel_b = 1'b0;
      sel_d = 1'b0;
      fz = '{16'h0c81, 16'h0f00, 16'h0001, 16'h0fff, 16'h0456, 16'h0789, 16'h5a1c, 16'h0013};
      rows = '{'{10'h334, 16'h0fff, 16'h0fff}, '{10'h336, 16'h0555, 16'h0555},
               '{10'h338, 16'h0800, 16'h0800}, '{10'h33a, 16'h0001, 16'h0001},
               '{10'h33c, 16'h0abc, 16'h0abc}, '{10'h33e, 16'h0123, 16'h0123},
               '{10'h360, 16'h001f, 16'h001f}, '{10'h361, 16'h0010, 16'h0010}};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      wait_load();
      // Every register holds its fuse word; gain registers keep only bits 7:0.
      for (int i = 0; i < 8; i++) begin
         rd_reg(rows[i].addr, v);
         chk_rd("fuse", (i < 6) ? fz[i] : {8'h00, fz[i][7:0]}, v);
      end
      chk_out("core4 fuse", fz[4][11:0], c4);
      chk_out("core0_fine_gain_trim fuse", {7'h00, fz[6][4:0]}, {7'h00, g0});
      // Write then read back at once, for each register in turn.
      for (int i = 0; i < 8; i++) begin
         wr_reg(rows[i].addr, rows[i].wdata);
         rd_reg(rows[i].addr, v);
         chk_rd("readback", rows[i].rexp, v);
      end
      repeat (2) @(posedge clk);
      #1;
      chk_out("core2 a", 12'hfff, c2);
      chk_out("core3 c", 12'h800, c3);
      chk_out("core4", 12'habc, c4);
      chk_out("core5", 12'h123, c5);
      chk_out("core0_fine_gain_trim", 12'h01f, {7'h00, g0});
      chk_out("core1_fine_gain_trim", 12'h010, {7'h00, g1});
      @(posedge clk);
      sel_b <= 1'b1;
      sel_d <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk_out("core2 b", 12'h555, c2);
      chk_out("core3 d", 12'h001, c3);
      // An unmapped write changes nothing and an unmapped read gives zero.
      wr_reg(10'h340, 16'h0abc);
      rd_reg(10'h340, v);
      chk_rd("unmapped", 16'h0000, v);
      rd_reg(10'h33e, v);
      chk_rd("core5 kept", 16'h0123, v);
      // A second reset reloads the fuses and a write during the load is dropped.
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      wr_reg(10'h33c, 16'h0777);
      idle();
      wait_load();
      rd_reg(10'h33c, v);
      chk_rd("reload", fz[4], v);
      chk_out("core4 reload", fz[4][11:0], c4);
      final_report();
   end

endmodule : adc_core_trim_registers_tb

//--- trim_pkg.sv
package trim_pkg;

   // ****************************************************************
   // Bus and field widths.
   // ****************************************************************
   localparam int ADDR_W = 10; // Register byte address width in bits.
   localparam int DATA_W = 16; // Register data width.
   localparam int OFS_W = 12; // Offset trim field width, bits 11:0.
   localparam int GAIN_W = 5; // Fine gain trim field width, bits 4:0.
   localparam int NUM_OFS = 6; // Offset trim registers in the bank.
   localparam int NUM_REGS = 8; // All trim registers in the bank.
   localparam int IDX_W = 3; // Width of a register index.

   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam logic [9:0] CORE2_INPUT_A_OFFSET_TRIM_ADDR = 10'h334;
   localparam logic [9:0] CORE2_INPUT_B_OFFSET_TRIM_ADDR = 10'h336;
   localparam logic [9:0] CORE3_INPUT_C_OFFSET_TRIM_ADDR = 10'h338;
   localparam logic [9:0] CORE3_INPUT_D_OFFSET_TRIM_ADDR = 10'h33a;
   localparam logic [9:0] CORE4_OFFSET_TRIM_ADDR = 10'h33c;
   localparam logic [9:0] CORE5_OFFSET_TRIM_ADDR = 10'h33e;
   localparam logic [9:0] CORE0_FINE_GAIN_TRIM_ADDR = 10'h360;
   localparam logic [9:0] CORE1_FINE_GAIN_TRIM_ADDR = 10'h361;

   // ****************************************************************
   // Register indices, reset values and writable masks.
   // ****************************************************************
   localparam logic [2:0] IDX_C2A = 3'h0; // Core 2, input pair A.
   localparam logic [2:0] IDX_C2B = 3'h1; // Core 2, input pair B.
   localparam logic [2:0] IDX_C3C = 3'h2; // Core 3, input pair C.
   localparam logic [2:0] IDX_C3D = 3'h3; // Core 3, input pair D.
   localparam logic [2:0] IDX_C4 = 3'h4; // Core 4 offset.
   localparam logic [2:0] IDX_C5 = 3'h5; // Core 5 offset.
   localparam logic [2:0] IDX_G0 = 3'h6; // Core 0 fine gain.
   localparam logic [2:0] IDX_G1 = 3'h7; // Core 1 fine gain.
   localparam logic [2:0] IDX_LAST = 3'h7; // Last fuse word index.
   localparam logic [15:0] OFS_RST = 16'h0000; // Nominal offset reset.
   localparam logic [15:0] GAIN_RST = 16'h0000; // Nominal gain reset.
   localparam logic [15:0] OFS_MASK = 16'hffff; // Offset register bits.
   localparam logic [15:0] GAIN_MASK = 16'h00ff; // Gain register bits.

   // ****************************************************************
   // Power-up fuse load sequencer states.
   // ****************************************************************
   typedef enum logic [1:0] {
      LOAD_ADDR,
      LOAD_WAIT,
      LOAD_DATA,
      LOAD_IDLE
   } load_state_t;

endpackage : trim_pkg
